//--- include/timer_event_flags_map.svh
`ifndef TIMER_EVENT_FLAGS_MAP_SVH
`define TIMER_EVENT_FLAGS_MAP_SVH

`define ADDR_W               8
`define DATA_W               16

`define REG_CTRL             8'h00
`define REG_MODULUS          8'h04
`define REG_COUNT            8'h08
`define REG_CHAN_CTRL_BASE   8'h0C
`define REG_CHAN_VALUE_BASE  8'h10
`define REG_CHAN_STRIDE      8'h08
`define REG_STATUS           8'h1C
`define REG_IRQ_ENABLE       8'h20

`define CTRL_COUNT_EN_BIT    0
`define CTRL_CENTER_BIT      1
`define CHCTRL_MODE_LO_BIT   0
`define CHCTRL_MODE_HI_BIT   1
`define CHCTRL_EDGE_LO_BIT   2
`define CHCTRL_EDGE_HI_BIT   3
`define STATUS_WRAP_BIT      0
`define STATUS_CHAN_BASE     1

`define CTRL_RESET           2'h0
`define CHCTRL_RESET         4'h0
`define MODULUS_RESET        16'h0000
`define COUNT_ZERO           16'h0000
`define COUNT_ONE            16'h0001
`define COUNT_MAX            16'hFFFF

`endif

//--- include/timer_event_flags_pkg.sv
package timer_event_flags_pkg;

   typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_EDGE_PWM, MODE_CENTER_PWM} chan_mode_t;

   typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage : timer_event_flags_pkg

//--- verilog/chan_unit.sv
`timescale 1ns/1ps
`include "timer_event_flags_map.svh"
module chan_unit
#(
   parameter int CNT_W = 16
)
(
   // Clock and synchronised reset
   input  wire logic                              sys_clk_in,
   input  wire logic                              rst_n_in,
   // Counter view
   input  wire logic [CNT_W-1:0]                  count_in,
   input  wire logic                              counting_in,
   input  wire logic                              reload_in,
   // Configuration
   input  wire timer_event_flags_pkg::chan_mode_t mode_in,
   input  wire logic [1:0]                        edge_sel_in,
   // Value register write
   input  wire logic                              value_wr_in,
   input  wire logic [CNT_W-1:0]                  value_wdata_in,
   // Channel pin
   input  wire logic                              pin_in,
   output logic                                   pin_out,
   output logic                                   pin_oe_n_out,
   // Results
   output logic                                   event_out,
   output logic [CNT_W-1:0]                       value_out
);

   logic             pin_prev_q;
   logic [CNT_W-1:0] value_q;
   logic [CNT_W-1:0] buffer_q;
   logic             pend_q;
   logic             pin_q;
   logic             oe_n_q;
   logic             rise;
   logic             fall;
   logic             capture_hit;
   logic             match;
   logic             is_pwm;
   logic             pwm_active;

   assign rise        = pin_in & ~pin_prev_q;
   assign fall        = ~pin_in & pin_prev_q;
   // Edge select 00 leaves capture off, 01 rising, 10 falling, 11 both.
   assign capture_hit = (mode_in == timer_event_flags_pkg::MODE_CAPTURE) &&
                        ((edge_sel_in[0] && rise) || (edge_sel_in[1] && fall));
   assign match       = counting_in && (count_in == value_q);
   assign is_pwm      = (mode_in == timer_event_flags_pkg::MODE_EDGE_PWM) ||
                        (mode_in == timer_event_flags_pkg::MODE_CENTER_PWM);
   // In center mode the counter passes the value going up and again going down.
   assign event_out   = capture_hit ||
                        ((mode_in != timer_event_flags_pkg::MODE_CAPTURE) && match);
   assign pwm_active  = (mode_in == timer_event_flags_pkg::MODE_CENTER_PWM) ?
                        (!value_q[CNT_W-1] && (count_in < value_q)) : (count_in < value_q);
   assign value_out   = value_q;
   assign pin_out     = pin_q;
   assign pin_oe_n_out = oe_n_q;

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         pin_prev_q <= 1'h0;
      else
         pin_prev_q <= pin_in;
   end

   // PWM values go through a buffer so a half-updated duty never reaches the compare.
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         value_q  <= '0;
         buffer_q <= '0;
         pend_q   <= 1'h0;
      end
      else
      begin
         if (capture_hit)
            value_q <= count_in;
         else if (reload_in && pend_q)
            value_q <= buffer_q;
         else if (value_wr_in && !is_pwm)
            value_q <= value_wdata_in;
         if (value_wr_in && is_pwm)
         begin
            buffer_q <= value_wdata_in;
            pend_q   <= 1'h1;
         end
         else if (reload_in)
            pend_q <= 1'h0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pin_q  <= 1'h0;
         oe_n_q <= 1'h1;
      end
      else
      begin
         unique case (mode_in)
            timer_event_flags_pkg::MODE_CAPTURE:
            begin
               pin_q  <= 1'h0;
               oe_n_q <= 1'h1;
            end
            timer_event_flags_pkg::MODE_COMPARE:
            begin
               oe_n_q <= (edge_sel_in == 2'h0);
               if (match && edge_sel_in == 2'h1)
                  pin_q <= ~pin_q;
               else if (match && edge_sel_in != 2'h0)
                  pin_q <= edge_sel_in[0];
            end
            timer_event_flags_pkg::MODE_EDGE_PWM,
            timer_event_flags_pkg::MODE_CENTER_PWM:
            begin
               oe_n_q <= 1'h0;
               pin_q  <= pwm_active ^ edge_sel_in[0];
            end
         endcase
      end
   end

   a_capture_copy: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      capture_hit |=> (value_q == $past(count_in)))
      else $error("Capture did not copy the counter into the value register.");

endmodule : chan_unit

//--- verilog/timer_event_flags.sv
// Contract
// - One wrap flag and one flag per channel, each able to raise an interrupt.
// - Capture mode sets the channel flag on every selected input edge.
// - Compare mode sets the channel flag when counter equals the channel value.
// - An enabled flag holds the interrupt request high as a level while set.
// - An event between that read and the zero write keeps the flag set.
// - Free-running up count wraps 0xFFFF to 0x0000 and sets the wrap flag.
// - With nonzero modulus, wrap flag sets on modulus to 0x0000 transition.
// - Up/down counting sets wrap flag when stepping down from the modulus value.
// - Two edge-select bits pick rising, falling, both or no capture edge.
// - Edge-aligned PWM sets the channel flag once per period at duty end.
// - Center-aligned PWM sets the channel flag at both value matches.
// - Mode bits pick capture, compare or edge PWM; center mode overrides them.
// - Center mode counts up to modulus, then down to zero.
// - A capture edge copies the counter into the channel value register.
`timescale 1ns/1ps
`include "timer_event_flags_map.svh"
module timer_event_flags
#(
   parameter int NUM_CHAN = 2
)
(
   // Clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  reset_n_in,
   // Register port
   input  wire logic [`ADDR_W-1:0]    reg_addr_in,
   input  wire logic [`DATA_W-1:0]    reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic      [`DATA_W-1:0]    reg_rdata_out,
   // Channel pins
   input  wire logic [NUM_CHAN-1:0]   chan_pin_in,
   output logic      [NUM_CHAN-1:0]   chan_pin_out,
   output logic      [NUM_CHAN-1:0]   chan_pin_oe_n_out,
   // Interrupt request
   output logic                       irq_out
);

   localparam int FLAG_W = NUM_CHAN + 1;

   logic [1:0]                       rst_sync_q;
   logic                             rst_n;
   logic [1:0]                       ctrl_q;
   logic [`DATA_W-1:0]               modulus_q;
   logic [`DATA_W-1:0]               count_q;
   timer_event_flags_pkg::count_dir_t dir_q;
   logic [NUM_CHAN-1:0][3:0]         chan_ctrl_q;
   logic [FLAG_W-1:0]                flag_q;
   logic [FLAG_W-1:0]                arm_q;
   logic [FLAG_W-1:0]                irq_en_q;
   logic [FLAG_W-1:0]                evt;
   logic [FLAG_W-1:0]                clr;
   logic [`DATA_W-1:0]               rdata_q;
   logic [`DATA_W-1:0]               rd_mux;
   logic [`DATA_W-1:0]               limit;
   logic [NUM_CHAN-1:0]              chan_ctrl_wr;
   logic [NUM_CHAN-1:0]              chan_val_wr;
   logic [NUM_CHAN-1:0]              chan_evt;
   logic [NUM_CHAN-1:0][`DATA_W-1:0] chan_value;
   logic                             counting;
   logic                             center;
   logic                             wr_status;
   logic                             rd_status;
   logic                             wr_count;
   logic                             wrap_evt;

   // Reset is asserted at once but released only after two clean edges.
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'h1};
   end

   assign rst_n     = rst_sync_q[1];
   assign counting  = ctrl_q[`CTRL_COUNT_EN_BIT];
   assign center    = ctrl_q[`CTRL_CENTER_BIT];
   assign wr_status = reg_wr_in && (reg_addr_in == `REG_STATUS);
   assign rd_status = reg_rd_in && (reg_addr_in == `REG_STATUS);
   assign wr_count  = reg_wr_in && (reg_addr_in == `REG_COUNT);

   always_comb
   begin
      chan_ctrl_wr = '0;
      chan_val_wr  = '0;
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         chan_ctrl_wr[i] = reg_wr_in &&
            (reg_addr_in == 8'(`REG_CHAN_CTRL_BASE + i * `REG_CHAN_STRIDE));
         chan_val_wr[i]  = reg_wr_in &&
            (reg_addr_in == 8'(`REG_CHAN_VALUE_BASE + i * `REG_CHAN_STRIDE));
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q      <= `CTRL_RESET;
         modulus_q   <= `MODULUS_RESET;
         irq_en_q    <= '0;
         chan_ctrl_q <= '0;
      end
      else
      begin
         if (reg_wr_in && reg_addr_in == `REG_CTRL)
            ctrl_q <= reg_wdata_in[1:0];
         if (reg_wr_in && reg_addr_in == `REG_MODULUS)
            modulus_q <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `REG_IRQ_ENABLE)
            irq_en_q <= reg_wdata_in[FLAG_W-1:0];
         for (int i = 0; i < NUM_CHAN; i++)
            if (chan_ctrl_wr[i])
               chan_ctrl_q[i] <= reg_wdata_in[3:0];
      end
   end

   // A zero modulus means the up counter runs the full 16-bit range.
   assign limit = (modulus_q == `MODULUS_RESET) ? `COUNT_MAX : modulus_q;

   // Center mode with a zero modulus never turns round, so the counter parks at zero.
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= `COUNT_ZERO;
         dir_q   <= timer_event_flags_pkg::DIR_UP;
      end
      else if (wr_count)
      begin
         count_q <= `COUNT_ZERO;
         dir_q   <= timer_event_flags_pkg::DIR_UP;
      end
      else if (counting && center)
      begin
         unique case (dir_q)
            timer_event_flags_pkg::DIR_UP:
            begin
               if (modulus_q == `MODULUS_RESET)
                  count_q <= `COUNT_ZERO;
               else if (count_q == modulus_q)
               begin
                  count_q <= count_q - `COUNT_ONE;
                  dir_q   <= timer_event_flags_pkg::DIR_DOWN;
               end
               else
                  count_q <= count_q + `COUNT_ONE;
            end
            timer_event_flags_pkg::DIR_DOWN:
            begin
               if (count_q == `COUNT_ZERO)
               begin
                  count_q <= `COUNT_ONE;
                  dir_q   <= timer_event_flags_pkg::DIR_UP;
               end
               else
                  count_q <= count_q - `COUNT_ONE;
            end
         endcase
      end
      else if (counting)
      begin
         dir_q <= timer_event_flags_pkg::DIR_UP;
         if (count_q == limit)
            count_q <= `COUNT_ZERO;
         else
            count_q <= count_q + `COUNT_ONE;
      end
   end

   assign wrap_evt = counting && !wr_count &&
      (center ? (dir_q == timer_event_flags_pkg::DIR_UP && modulus_q != `MODULUS_RESET && count_q == modulus_q)
              : (count_q == limit));

   for (genvar g = 0; g < NUM_CHAN; g++)
   begin : g_chan
      timer_event_flags_pkg::chan_mode_t mode;

      // Center alignment overrides the per-channel mode bits.
      assign mode = center ? timer_event_flags_pkg::MODE_CENTER_PWM :
                    chan_ctrl_q[g][`CHCTRL_MODE_HI_BIT] ? timer_event_flags_pkg::MODE_EDGE_PWM :
                    chan_ctrl_q[g][`CHCTRL_MODE_LO_BIT] ? timer_event_flags_pkg::MODE_COMPARE :
                    timer_event_flags_pkg::MODE_CAPTURE;

      chan_unit #(.CNT_W(`DATA_W)) u_chan
      (
         .sys_clk_in     (sys_clk_in),
         .rst_n_in       (rst_n),
         .count_in       (count_q),
         .counting_in    (counting && !wr_count),
         .reload_in      (wrap_evt),
         .mode_in        (mode),
         .edge_sel_in    ({chan_ctrl_q[g][`CHCTRL_EDGE_HI_BIT], chan_ctrl_q[g][`CHCTRL_EDGE_LO_BIT]}),
         .value_wr_in    (chan_val_wr[g]),
         .value_wdata_in (reg_wdata_in),
         .pin_in         (chan_pin_in[g]),
         .pin_out        (chan_pin_out[g]),
         .pin_oe_n_out   (chan_pin_oe_n_out[g]),
         .event_out      (chan_evt[g]),
         .value_out      (chan_value[g])
      );
   end

   assign evt = {chan_evt, wrap_evt};

   // A read arms only the bits it saw set; any later event disarms its bit again.
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
         arm_q <= '0;
      else if (rd_status)
         arm_q <= flag_q & ~evt;
      else if (wr_status)
         arm_q <= '0;
      else
         arm_q <= arm_q & ~evt;
   end

   assign clr = {FLAG_W{wr_status}} & arm_q & ~reg_wdata_in[FLAG_W-1:0] & ~evt;

   // A set in the same cycle as a clear wins.
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
         flag_q <= '0;
      else
         flag_q <= evt | (flag_q & ~clr);
   end

   assign irq_out = |(flag_q & irq_en_q);

   always_comb
   begin
      rd_mux = '0;
      if (reg_addr_in == `REG_CTRL)
         rd_mux[1:0] = ctrl_q;
      else if (reg_addr_in == `REG_MODULUS)
         rd_mux = modulus_q;
      else if (reg_addr_in == `REG_COUNT)
         rd_mux = count_q;
      else if (reg_addr_in == `REG_STATUS)
         rd_mux[FLAG_W-1:0] = flag_q;
      else if (reg_addr_in == `REG_IRQ_ENABLE)
         rd_mux[FLAG_W-1:0] = irq_en_q;
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         if (reg_addr_in == 8'(`REG_CHAN_CTRL_BASE + i * `REG_CHAN_STRIDE))
            rd_mux[3:0] = chan_ctrl_q[i];
         if (reg_addr_in == 8'(`REG_CHAN_VALUE_BASE + i * `REG_CHAN_STRIDE))
            rd_mux = chan_value[i];
      end
   end

   // Read data stand for exactly one cycle; otherwise the bus reads zero.
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= '0;
      else if (reg_rd_in)
         rdata_q <= rd_mux;
      else
         rdata_q <= '0;
   end

   assign reg_rdata_out = rdata_q;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n);

   sequence s_armed_read(int k);
      rd_status && flag_q[k] && !evt[k];
   endsequence

   sequence s_zero_write(int k);
      wr_status && !reg_wdata_in[k] && !evt[k];
   endsequence

   a_wrap_up: assert property (
      (counting && !center && !wr_count && count_q == limit) |=> (flag_q[0] && count_q == `COUNT_ZERO))
      else $error("Up count did not wrap to zero and set the wrap flag.");

   a_center_turn: assert property (
      (counting && center && !wr_count && dir_q == timer_event_flags_pkg::DIR_UP &&
       modulus_q != `MODULUS_RESET && count_q == modulus_q)
      |=> (flag_q[0] && dir_q == timer_event_flags_pkg::DIR_DOWN && count_q == $past(modulus_q) - `COUNT_ONE))
      else $error("Center count did not turn down at the modulus with the wrap flag.");

   a_center_bottom: assert property (
      (counting && center && !wr_count && dir_q == timer_event_flags_pkg::DIR_DOWN && count_q == `COUNT_ZERO)
      |=> (dir_q == timer_event_flags_pkg::DIR_UP && count_q == `COUNT_ONE && !flag_q[0] == !$past(flag_q[0])))
      else $error("Center count did not turn up at zero.");

   a_read_timing: assert property (
      rd_status |=> (reg_rdata_out == `DATA_W'($past(flag_q))) ##1 (reg_rdata_out == '0 || $past(reg_rd_in)))
      else $error("Status read data not presented for exactly one cycle.");

   a_reset_quiet: assert property ($rose(rst_n) |-> (!irq_out && flag_q == '0))
      else $error("Interrupt request or flag present after reset.");

   for (genvar k = 0; k < FLAG_W; k++)
   begin : g_flag_chk
      a_event_sets: assert property (evt[k] |=> flag_q[k])
         else $error("Event did not set its flag.");

      a_irq_level: assert property ((flag_q[k] && irq_en_q[k]) |-> irq_out [*2] or ##1 !flag_q[k] or ##1 !irq_en_q[k])
         else $error("Enabled flag did not hold the interrupt request.");

      a_clear_seq: assert property (s_armed_read(k) ##1 s_zero_write(k) |=> !flag_q[k])
         else $error("Read then zero write did not clear the flag.");

      a_event_wins: assert property (
         (s_armed_read(k) ##1 (evt[k] && !wr_status && !rd_status) ##1 s_zero_write(k)) |=> flag_q[k])
         else $error("Event between read and write was lost.");

      a_no_blind_clear: assert property (
         (flag_q[k] && wr_status && (reg_wdata_in[k] || !arm_q[k])) |=> flag_q[k])
         else $error("Flag cleared without a qualifying read and zero write.");
   end

endmodule : timer_event_flags

//--- testbench/pin_partner.sv
`timescale 1ns/1ps
module pin_partner
#(
   parameter int NUM_CHAN = 2
)
(
   // Clock
   input  wire logic                sys_clk_in,
   // Level requested from the outside source
   input  wire logic [NUM_CHAN-1:0] ext_level_in,
   // Block side of the pin
   input  wire logic [NUM_CHAN-1:0] pin_drive_in,
   input  wire logic [NUM_CHAN-1:0] pin_oe_n_in,
   output logic      [NUM_CHAN-1:0] pin_level_out
);
   logic [NUM_CHAN-1:0] ext_q;

   // The source is registered so that every edge it makes is clean and synchronous to the clock.
   always_ff @(posedge sys_clk_in)
   begin
      ext_q <= ext_level_in;
   end

   // The block wins the wire whenever its enable is low; otherwise the outside source sets the level.
   always_comb
   begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         pin_level_out[i] = pin_oe_n_in[i] ? ext_q[i] : pin_drive_in[i];
      end
   end
endmodule : pin_partner

//--- testbench/timer_event_flags_bench.sv
`timescale 1ns/1ps
`include "timer_event_flags_map.svh"
module timer_event_flags_bench;
   logic               sys_clk;
   logic               reset_n;
   logic [7:0]         addr;
   logic [15:0]        wdata;
   logic               wr;
   logic               rd;
   logic [15:0]        rdata;
   logic [1:0]         pin_level;
   logic [1:0]         pin_drive;
   logic [1:0]         pin_oe_n;
   logic [1:0]         ext_level;
   logic               irq;
   logic [15:0]        d;
   int                 num_errors;
   int                 total_checks;

   localparam logic [7:0] CH1_CTRL = `REG_CHAN_CTRL_BASE + `REG_CHAN_STRIDE;
   localparam logic [7:0] CH1_VAL  = `REG_CHAN_VALUE_BASE + `REG_CHAN_STRIDE;

   timer_event_flags #(.NUM_CHAN(2)) i_dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .chan_pin_in(pin_level),
      .chan_pin_out(pin_drive), .chan_pin_oe_n_out(pin_oe_n), .irq_out(irq));

   pin_partner #(.NUM_CHAN(2)) i_pins (.sys_clk_in(sys_clk), .ext_level_in(ext_level),
      .pin_drive_in(pin_drive), .pin_oe_n_in(pin_oe_n), .pin_level_out(pin_level));

   always #10 sys_clk = ~sys_clk;

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg

   // Software clear: read the flags, then write zero to them in the very next cycle.
   task automatic clear_flags();
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= `REG_STATUS;
      @(posedge sys_clk);
      rd    <= 1'b0;
      wr    <= 1'b1;
      wdata <= 16'h0000;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : clear_flags

   task automatic wait_flag(input int b, input int lim);
      int i;
      for (i = 0; i < lim; i++)
      begin
         rd_reg(`REG_STATUS, d);
         if (d[b] === 1'b1)
            break;
      end
      chk({15'h0000, i < lim}, 16'h0001, "flag did not rise in time");
      if (i >= lim)
         give_verdict();
   endtask : wait_flag

   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   initial
   begin
      sys_clk = 1'b0;
      reset_n = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      ext_level = 2'h0;
      num_errors = 0;
      total_checks = 0;
      tick(20);
      reset_n <= 1'b1;
      tick(3);
      chk({15'h0000, irq}, 16'h0000, "irq after reset");
      chk({14'h0000, pin_oe_n}, 16'h0003, "pins released after reset");
      chk({14'h0000, pin_drive}, 16'h0000, "pin levels after reset");
      rd_reg(`REG_STATUS, d);
      chk(d, 16'h0000, "status after reset");
      rd_reg(`REG_IRQ_ENABLE, d);
      chk(d, 16'h0000, "enables after reset");
      rd_reg(8'h40, d);
      chk(d, 16'h0000, "unmapped read");

      // Capture on channel 0 with a stopped counter, for every edge selection.
      wr_reg(`REG_COUNT, 16'h0000);
      wr_reg(`REG_CHAN_VALUE_BASE, 16'hFFFF);
      for (int s = 0; s < 4; s++)
      begin
         wr_reg(`REG_CHAN_CTRL_BASE, 16'(s << 2));
         clear_flags();
         ext_level <= 2'h1;
         tick(4);
         rd_reg(`REG_STATUS, d);
         chk({15'h0000, d[1]}, {15'h0000, s == 1 || s == 3}, "rising edge flag");
         clear_flags();
         ext_level <= 2'h0;
         tick(4);
         rd_reg(`REG_STATUS, d);
         chk({15'h0000, d[1]}, {15'h0000, s >= 2}, "falling edge flag");
      end
      rd_reg(`REG_CHAN_VALUE_BASE, d);
      chk(d, 16'h0000, "captured count");

      // A capture edge in the cycle between the read and the zero write must keep the flag.
      @(posedge sys_clk);
      rd        <= 1'b1;
      addr      <= `REG_STATUS;
      ext_level <= 2'h1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(posedge sys_clk);
      wr    <= 1'b1;
      wdata <= 16'h0000;
      @(posedge sys_clk);
      wr <= 1'b0;
      rd_reg(`REG_STATUS, d);
      chk({15'h0000, d[1]}, 16'h0001, "flag kept by racing capture");

      // Compare on channel 1, then edge PWM on channel 1.
      wr_reg(CH1_CTRL, 16'h0001);
      wr_reg(CH1_VAL, 16'h0005);
      clear_flags();
      wr_reg(`REG_CTRL, 16'h0001);
      wait_flag(2, 10);
      chk({15'h0000, pin_oe_n[1]}, 16'h0001, "compare pin left free");
      wr_reg(`REG_CTRL, 16'h0000);
      wr_reg(CH1_CTRL, 16'h0002);
      wr_reg(CH1_VAL, 16'h0003);
      wr_reg(`REG_MODULUS, 16'h0007);
      wr_reg(`REG_COUNT, 16'h0000);
      clear_flags();
      wr_reg(`REG_CTRL, 16'h0001);
      wait_flag(2, 20);
      chk({15'h0000, pin_oe_n[1]}, 16'h0000, "edge PWM pin driven");

      // Wrap at the modulus, masking, the clear sequence and a racing event.
      wr_reg(`REG_CTRL, 16'h0000);
      wr_reg(CH1_CTRL, 16'h0000);
      wr_reg(`REG_MODULUS, 16'h0003);
      wr_reg(`REG_COUNT, 16'h0000);
      clear_flags();
      wr_reg(`REG_CTRL, 16'h0001);
      wait_flag(0, 10);
      chk({15'h0000, irq}, 16'h0000, "masked irq");
      wr_reg(`REG_IRQ_ENABLE, 16'h0007);
      #1;
      chk({15'h0000, irq}, 16'h0001, "enabled irq");
      rd_reg(`REG_STATUS, d);
      tick(8);
      // The counter stops before the write, so only the disarm by the wraps can keep the flag.
      wr_reg(`REG_CTRL, 16'h0000);
      wr_reg(`REG_STATUS, 16'h0000);
      rd_reg(`REG_STATUS, d);
      chk({15'h0000, d[0]}, 16'h0001, "flag kept by new wrap");
      clear_flags();
      rd_reg(`REG_STATUS, d);
      chk(d, 16'h0000, "flags cleared");
      chk({15'h0000, irq}, 16'h0000, "irq after clear");
      wr_reg(`REG_CTRL, 16'h0001);
      tick(6);
      wr_reg(`REG_CTRL, 16'h0000);
      rd_reg(`REG_STATUS, d);
      wr_reg(`REG_STATUS, 16'h0001);
      wr_reg(`REG_STATUS, 16'h0000);
      rd_reg(`REG_STATUS, d);
      chk({15'h0000, d[0]}, 16'h0001, "flag after one and unarmed zero");
      chk({15'h0000, irq}, 16'h0001, "irq stays high");

      // Center mode: count stays within the modulus and both flags fire.
      wr_reg(CH1_VAL, 16'h0002);
      wr_reg(`REG_COUNT, 16'h0000);
      clear_flags();
      wr_reg(`REG_CTRL, 16'h0003);
      for (int k = 0; k < 8; k++)
      begin
         rd_reg(`REG_COUNT, d);
         chk({15'h0000, d > 16'h0003}, 16'h0000, "center count above modulus");
      end
      wait_flag(2, 10);
      wait_flag(0, 10);

      // Free-running count with no modulus wraps only after 0xFFFF.
      wr_reg(`REG_CTRL, 16'h0000);
      wr_reg(`REG_MODULUS, 16'h0000);
      wr_reg(`REG_COUNT, 16'h0000);
      clear_flags();
      wr_reg(`REG_CTRL, 16'h0001);
      tick(65000);
      rd_reg(`REG_STATUS, d);
      chk({15'h0000, d[0]}, 16'h0000, "early wrap");
      wait_flag(0, 400);
      give_verdict();
   end
endmodule : timer_event_flags_bench
